// ===== common/brake_pkg.sv
// constants, types and register map of the overtravel stop and brake interlock block
package brake_pkg;
  localparam int CLK_HZ = 250000000;
  localparam int TICK_MS = 1; // timer tick period in ms
  localparam int CYC_PER_MS = CLK_HZ / 1000 * TICK_MS;
  localparam logic [13:0] MS_PER_UNIT = 14'h00A; // 10 ms parameter unit
  // register word offsets (byte addresses)
  localparam logic [7:0] A_STOP = 8'h00;
  localparam logic [7:0] A_PLUG = 8'h04;
  localparam logic [7:0] A_OFUNC = 8'h08;
  localparam logic [7:0] A_SON = 8'h0C;
  localparam logic [7:0] A_BASE = 8'h10;
  localparam logic [7:0] A_BSPD = 8'h14;
  localparam logic [7:0] A_BWAIT = 8'h18;
  localparam logic [7:0] A_STAT = 8'h1C;
  // reset values
  localparam logic [2:0] STOP_RST = 3'h0;
  localparam logic [8:0] PLUG_RST = 9'h12C; // 300 percent
  localparam logic [8:0] TRQ_MAX = 9'h12C;
  localparam logic [11:0] OFUNC_RST = 12'h210; // no digit carries the brake
  localparam logic [11:0] SON_RST = 12'h000;
  localparam logic [8:0] BASE_RST = 9'h000;
  localparam logic [6:0] BSPD_RST = 7'h64; // 100 rpm
  localparam logic [6:0] BWAIT_RST = 7'h32; // 50 units
  // output function codes
  localparam logic [3:0] FN_BRAKE = 4'h4;
  localparam logic [3:0] FN_OT = 4'h6;
  localparam int N_TERM = 3;
  // status register field positions
  localparam int ST_STATE = 0;
  localparam int ST_METHOD = 8;
  localparam int ST_BRAKE = 12;
  localparam int ST_MODE = 16;

  typedef enum logic [6:0] {
    S_OFF = 7'h01, S_ON_WAIT = 7'h02, S_RUN = 7'h04, S_OT_STOP = 7'h08,
    S_OT_HOLD = 7'h10, S_IDLE_STOP = 7'h20, S_RUN_STOP = 7'h40
  } state_e;

  typedef enum logic [2:0] {
    MODE_COAST = 3'h0, MODE_DYN = 3'h1, MODE_PLUG = 3'h2,
    MODE_ZCLAMP = 3'h3, MODE_DRIVE = 3'h4
  } mode_e;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    mode_e mode; // power stage command
    logic [8:0] torque_limit; // percent of rated torque
    logic zero_ref; // position loop held at reference zero
  } motor_cmd_s;
endpackage : brake_pkg

// ===== core/overtravel_brake.sv
// overtravel stop method, zero clamp, brake interlock timing and output routing
//
// Chosen here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
// Functional notes
// (RULE1) method 0: overtravel stop by dynamic braking, then coast unpowered.
// (RULE2) method 1: coast to stop like servo off, then stay coasting.
// (RULE3) methods 2,3: plug brake on overtravel then coast; servo off dynamic or coast.
// (RULE4) methods 4,5: plug brake on overtravel then zero clamp; servo off dynamic or coast.
// (RULE5) new stop method applies only after both supplies cycle.
// (RULE6) zero clamp holds position loop on reference zero.
// (RULE7) plug braking torque capped at programmed limit, default 300, immediate.
// (RULE8) brake output low releases brake, high applies it.
// (RULE9) brake drives only terminals whose selector holds the brake code.
// (RULE10) each selector digit routes one terminal; code 4 gives brake.
// (RULE11) codes 0 to B map to the listed status functions.
// (RULE12) by default brake applies with servo off; delay shifts power removal.
// (RULE13) servo on delay signed ms and base wait in 10 ms, immediate.
// (RULE14) running stop uses brake speed threshold and brake wait time.
// (RULE15) running: brake applies at low speed or timeout, whichever first.
module overtravel_brake #(
  parameter int CYC_MS = brake_pkg::CYC_PER_MS
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input brake_pkg::wb_req_s wb_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic fwd_travel_limit_in, // pin, high = forward prohibited
  input wire logic rev_travel_limit_in, // pin, high = reverse prohibited
  input wire logic servo_on_in, // pin, high = servo on request
  input wire logic power_ok_in, // pin, high while both supplies are up
  input wire logic alarm_in,
  input wire logic dir_fwd_in, // motion direction, high = forward
  input wire logic [15:0] speed_in, // speed magnitude in rpm
  input wire logic [11:0] func_status_in, // other output functions, high = on
  output brake_pkg::motor_cmd_s cmd_out,
  output logic brake_release_out, // low releases brake
  output logic [2:0] term_n_out // output terminals, low = on
);
  import brake_pkg::*;

  // pin synchronisers: three stages, accept when stages two and three agree
  logic [3:0] pin_raw;
  logic [3:0] s1, s2, s3, pin;
  assign pin_raw = {power_ok_in, servo_on_in, rev_travel_limit_in, fwd_travel_limit_in};
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge clock_in) begin
        if (rst_in) begin
          s1[g] <= 1'b0;
          s2[g] <= 1'b0;
          s3[g] <= 1'b0;
          pin[g] <= 1'b0;
        end else begin
          s1[g] <= pin_raw[g];
          s2[g] <= s1[g];
          s3[g] <= s2[g];
          if (s2[g] == s3[g]) pin[g] <= s3[g];
        end
      end
    end
  endgenerate

  wire fwd_lim = pin[0];
  wire rev_lim = pin[1];
  wire son = pin[2];
  wire pwr = pin[3];
  logic pwr_d;

  // registers
  logic [2:0] stop_method_param, method;
  logic [8:0] plug_torque_limit;
  logic [11:0] output_function_select;
  logic [11:0] servo_on_delay;
  logic [8:0] base_wait_delay;
  logic [6:0] brake_speed_threshold, brake_wait_timeout;
  state_e state, next_state;

  // wishbone decode
  wire req = wb_in.cyc & wb_in.stb & ~wb_ack_out;
  wire wr = req & wb_in.we & (&wb_in.sel);
  wire [31:0] d = wb_in.dat;
  wire [31:0] stat = {13'h0000, cmd_out.mode, 3'h0, ~brake_release_out,
                      1'b0, method, 1'b0, state};
  logic [31:0] rd;
  always_comb begin
    if (wb_in.adr == A_STOP) rd = {29'h0, stop_method_param};
    else if (wb_in.adr == A_PLUG) rd = {23'h0, plug_torque_limit};
    else if (wb_in.adr == A_OFUNC) rd = {20'h0, output_function_select};
    else if (wb_in.adr == A_SON) rd = {20'h0, servo_on_delay};
    else if (wb_in.adr == A_BASE) rd = {23'h0, base_wait_delay};
    else if (wb_in.adr == A_BSPD) rd = {25'h0, brake_speed_threshold};
    else if (wb_in.adr == A_BWAIT) rd = {25'h0, brake_wait_timeout};
    else if (wb_in.adr == A_STAT) rd = stat;
    else rd = 32'h0000_0000; // unmapped reads zero, still acked
  end

  // bus answer one cycle after the request is seen
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= req;
      wb_dat_out <= req ? rd : 32'h0000_0000;
    end
  end

  // register writes; every setting except the stop method applies at once
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      stop_method_param <= STOP_RST;
      plug_torque_limit <= PLUG_RST;
      output_function_select <= OFUNC_RST;
      servo_on_delay <= SON_RST;
      base_wait_delay <= BASE_RST;
      brake_speed_threshold <= BSPD_RST;
      brake_wait_timeout <= BWAIT_RST;
    end else if (wr) begin
      if (wb_in.adr == A_STOP) stop_method_param <= d[2:0];
      else if (wb_in.adr == A_PLUG) plug_torque_limit <= d[8:0]; // [RULE7]
      else if (wb_in.adr == A_OFUNC) output_function_select <= d[11:0]; // [RULE10]
      else if (wb_in.adr == A_SON) servo_on_delay <= d[11:0]; // [RULE13]
      else if (wb_in.adr == A_BASE) base_wait_delay <= d[8:0]; // [RULE13]
      else if (wb_in.adr == A_BSPD) brake_speed_threshold <= d[6:0]; // [RULE14]
      else if (wb_in.adr == A_BWAIT) brake_wait_timeout <= d[6:0]; // [RULE14]
    end
  end

  // active stop method follows the written value only on a supply restart
  wire pwr_up = pwr & ~pwr_d;
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pwr_d <= 1'b0;
      method <= STOP_RST;
    end else begin
      pwr_d <= pwr;
      if (pwr_up) method <= stop_method_param; // [RULE5]
    end
  end

  // millisecond timer, restarted on every state change
  logic [17:0] pre;
  logic [13:0] tmr;
  wire tick = (pre == 18'(CYC_MS - 1));
  always_ff @(posedge clock_in) begin
    if (rst_in || next_state != state) begin
      pre <= 18'h00000;
      tmr <= 14'h0000;
    end else begin
      pre <= tick ? 18'h00000 : pre + 18'h00001;
      if (tick && tmr != 14'h3FFF) tmr <= tmr + 14'h0001;
    end
  end

  // timing decode
  wire son_neg = servo_on_delay[11];
  wire [13:0] son_abs = son_neg ? {2'b00, 12'(-servo_on_delay)} : {2'b00, servo_on_delay};
  wire [13:0] base_ms = 14'(base_wait_delay * MS_PER_UNIT);
  wire [13:0] bwait_ms = 14'(brake_wait_timeout * MS_PER_UNIT);
  wire slow = speed_in < {9'h000, brake_speed_threshold};
  wire stopped = speed_in == 16'h0000;
  wire off_req = ~son | alarm_in;
  wire ot = (fwd_lim & dir_fwd_in) | (rev_lim & ~dir_fwd_in);
  // the timer still belongs to the old state on entry, so only a zero delay counts as done there
  wire son_done = (state == S_ON_WAIT) ? (tmr >= son_abs) : (son_abs == 14'h0000);

  // state sequencing
  always_comb begin
    next_state = state;
    case (state)
      S_OFF: if (son & ~alarm_in) next_state = S_ON_WAIT;
      S_ON_WAIT: begin
        if (off_req) next_state = S_OFF;
        else if (son_done) next_state = S_RUN;
      end
      S_RUN, S_OT_STOP: begin
        if (off_req) next_state = slow ? S_IDLE_STOP : S_RUN_STOP; // [RULE14]
        else if (state == S_RUN && ot) next_state = S_OT_STOP;
        else if (state == S_OT_STOP && stopped) next_state = S_OT_HOLD;
      end
      S_OT_HOLD: begin
        if (off_req) next_state = S_IDLE_STOP;
        else if (!ot) next_state = S_RUN;
      end
      S_IDLE_STOP: if (tmr >= base_ms) next_state = S_OFF; // [RULE12]
      S_RUN_STOP: if (slow || tmr >= bwait_ms) next_state = S_OFF; // [RULE15]
      default: next_state = S_OFF;
    endcase
  end

  // stop modes chosen by the active method
  wire odd = method[0];
  wire plug_m = method >= 3'h2;
  mode_e ot_mode, off_mode, hold_mode;
  assign ot_mode = plug_m ? MODE_PLUG : (odd ? MODE_COAST : MODE_DYN); // [RULE1] [RULE2] [RULE3]
  assign off_mode = odd ? MODE_COAST : MODE_DYN; // [RULE3] [RULE4]
  assign hold_mode = (method >= 3'h4) ? MODE_ZCLAMP : MODE_COAST; // [RULE4]

  // motor command and brake level for the next cycle
  motor_cmd_s next_cmd;
  logic next_brake_n;
  always_comb begin
    next_cmd = '{MODE_COAST, TRQ_MAX, 1'b0};
    next_brake_n = 1'b1;
    case (next_state)
      S_ON_WAIT: begin
        if (!son_neg || son_done) next_brake_n = 1'b0;
        if (son_neg || son_done) next_cmd.mode = MODE_DRIVE;
      end
      S_RUN: begin
        next_cmd.mode = MODE_DRIVE;
        next_brake_n = 1'b0; // [RULE8]
      end
      S_OT_STOP: begin
        next_cmd.mode = ot_mode;
        next_brake_n = 1'b0;
        if (plug_m) next_cmd.torque_limit = plug_torque_limit; // [RULE7]
      end
      S_OT_HOLD: begin
        next_cmd.mode = hold_mode;
        next_cmd.zero_ref = hold_mode == MODE_ZCLAMP; // [RULE6]
        next_brake_n = 1'b0;
      end
      S_IDLE_STOP: next_cmd.mode = MODE_DRIVE; // brake on, power held [RULE12]
      S_RUN_STOP: begin
        next_cmd.mode = off_mode;
        next_brake_n = 1'b0;
      end
      default: next_cmd.mode = MODE_COAST;
    endcase
  end

  // output function selection per terminal digit
  function automatic logic fn_sel(input logic [3:0] code, input logic [11:0] st,
                                  input logic bk, input logic otf);
    if (code == FN_BRAKE) fn_sel = bk; // [RULE9] [RULE10]
    else if (code == FN_OT) fn_sel = otf;
    else if (code <= 4'hB) fn_sel = st[code]; // [RULE11]
    else fn_sel = 1'b0;
  endfunction : fn_sel

  wire ot_any = fwd_lim | rev_lim;
  logic [2:0] next_term_n;
  generate
    for (g = 0; g < N_TERM; g++) begin : g_term
      assign next_term_n[g] = ~fn_sel(output_function_select[4*g+:4], func_status_in,
                                      ~next_brake_n, ot_any);
    end
  endgenerate

  // state and output flops
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state <= S_OFF;
      cmd_out <= '{MODE_COAST, TRQ_MAX, 1'b0};
      brake_release_out <= 1'b1;
      term_n_out <= 3'h7;
    end else begin
      state <= next_state;
      cmd_out <= next_cmd;
      brake_release_out <= next_brake_n; // [RULE8]
      term_n_out <= next_term_n;
    end
  end

  // checks
  property p_ot_dyn;
    @(posedge clock_in) disable iff (rst_in)
    state == S_RUN && !off_req && ot && method == 3'h0 |=> cmd_out.mode == MODE_DYN;
  endproperty
  a_ot_dyn: assert property (p_ot_dyn) else $error("method 0 not dynamic braking"); // [RULE1]
  property p_ot_coast;
    @(posedge clock_in) disable iff (rst_in)
    state == S_OT_STOP && method == 3'h1 |-> cmd_out.mode == MODE_COAST;
  endproperty
  a_ot_coast: assert property (p_ot_coast) else $error("method 1 not coasting"); // [RULE2]
  property p_ot_plug;
    @(posedge clock_in) disable iff (rst_in)
    state == S_OT_STOP && plug_m |-> cmd_out.mode == MODE_PLUG
      && cmd_out.torque_limit == $past(plug_torque_limit);
  endproperty
  a_ot_plug: assert property (p_ot_plug) else $error("plug braking wrong"); // [RULE3] [RULE7]
  property p_hold;
    @(posedge clock_in) disable iff (rst_in)
    state == S_OT_HOLD && $stable(method) |-> cmd_out.zero_ref == (method >= 3'h4);
  endproperty
  a_hold: assert property (p_hold) else $error("hold mode wrong"); // [RULE4] [RULE6]
  property p_method;
    @(posedge clock_in) disable iff (rst_in)
    !pwr_up |=> $stable(method);
  endproperty
  a_method: assert property (p_method) else $error("stop method changed early"); // [RULE5]
  property p_off_brake;
    @(posedge clock_in) disable iff (rst_in)
    state == S_OFF |-> brake_release_out && cmd_out.mode == MODE_COAST;
  endproperty
  a_off_brake: assert property (p_off_brake) else $error("brake released when off"); // [RULE8]
  property p_route;
    @(posedge clock_in) disable iff (rst_in)
    $stable(output_function_select) && output_function_select[7:4] == FN_BRAKE
      |-> term_n_out[1] == brake_release_out;
  endproperty
  a_route: assert property (p_route) else $error("brake not routed"); // [RULE10]
  property p_idle;
    @(posedge clock_in) disable iff (rst_in)
    state == S_RUN && off_req && slow |=> brake_release_out
      ##0 (state == S_IDLE_STOP || state == S_OFF);
  endproperty
  a_idle: assert property (p_idle) else $error("brake late at servo off"); // [RULE12]
  property p_run_stop;
    @(posedge clock_in) disable iff (rst_in)
    state == S_RUN_STOP && slow |=> state == S_OFF && brake_release_out;
  endproperty
  a_run_stop: assert property (p_run_stop) else $error("brake not applied"); // [RULE15]
  c_ot_plug: cover property (@(posedge clock_in) state == S_OT_STOP && plug_m);
  c_zclamp: cover property (@(posedge clock_in) cmd_out.mode == MODE_ZCLAMP);
  c_run_stop: cover property (@(posedge clock_in) state == S_RUN_STOP ##1 state == S_OFF);
endmodule : overtravel_brake

// ===== verif/brake_limit_model.sv
// travel limit switches and brake control relay on the far side of the block
`timescale 1ns/1ps
module brake_limit_model (
  input wire logic clock_in,
  input wire logic fwd_hit_in, // bench trips the forward switch
  input wire logic rev_hit_in, // bench trips the reverse switch
  input wire logic brake_release_in, // interlock output, low = release
  output logic fwd_travel_limit_out, // high = forward prohibited
  output logic rev_travel_limit_out, // high = reverse prohibited
  output logic relay_on_out // relay energised, brake lifted
);
  // contacts change just after a clock edge, like a debounced switch
  always_ff @(posedge clock_in) begin
    fwd_travel_limit_out <= fwd_hit_in;
    rev_travel_limit_out <= rev_hit_in;
  end
  // relay pulls in only while the interlock output is low
  assign relay_on_out = (brake_release_in === 1'b0);
endmodule : brake_limit_model

// ===== verif/testbench.sv
// self-checking bench for the overtravel stop and brake interlock block
`timescale 1ns/1ps
module testbench;
  import brake_pkg::*;
  logic clock_in;
  logic rst_in = 1'b1;
  logic servo_on = 1'b0;
  logic power_ok = 1'b1;
  logic alarm = 1'b0;
  logic dir_fwd = 1'b1;
  logic fwd_hit = 1'b0;
  logic rev_hit = 1'b0;
  logic [15:0] speed = 16'h0000;
  logic [11:0] fstat = 12'h000;
  wb_req_s wb = '0;
  logic [31:0] wb_dat;
  logic wb_ack, brake_n, fwd_lim, rev_lim, relay_on;
  logic [2:0] term_n;
  motor_cmd_s cmd;
  int num_errors = 0;
  int n_tests = 0;
  integer seed = 32'h7AFE;
  int g;
  logic [31:0] rd;
  logic [8:0] lim;
  logic [11:0] ofunc;
  logic [3:0] codes [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA,
                             4'hB, 4'hC};

  overtravel_brake #(.CYC_MS(4)) overtravel_brake_i (
    .clock_in(clock_in), .rst_in(rst_in), .wb_in(wb), .wb_dat_out(wb_dat),
    .wb_ack_out(wb_ack), .fwd_travel_limit_in(fwd_lim), .rev_travel_limit_in(rev_lim),
    .servo_on_in(servo_on), .power_ok_in(power_ok), .alarm_in(alarm),
    .dir_fwd_in(dir_fwd), .speed_in(speed), .func_status_in(fstat), .cmd_out(cmd),
    .brake_release_out(brake_n), .term_n_out(term_n));

  brake_limit_model brake_limit_model_i (
    .clock_in(clock_in), .fwd_hit_in(fwd_hit), .rev_hit_in(rev_hit),
    .brake_release_in(brake_n), .fwd_travel_limit_out(fwd_lim),
    .rev_travel_limit_out(rev_lim), .relay_on_out(relay_on));

  // compare one result and count it
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // classic single wishbone cycle, held until ack is sampled
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    chk("ack", 1, wb_ack);
    rd = wb_dat;
    wb <= '0;
    @(posedge clock_in);
  endtask : bus

  // wait a bounded time for the interlock output to reach a level
  task automatic wait_brake(input logic lvl, input int lim_c);
    int n;
    n = 0;
    while (brake_n !== lvl && n < lim_c) begin
      @(posedge clock_in);
      n++;
    end
    chk("brake", lvl, brake_n);
  endtask : wait_brake

  // mode expected while stopping on a travel limit
  function automatic logic [2:0] stop_mode(input int m);
    return (m == 0) ? MODE_DYN : (m == 1) ? MODE_COAST : MODE_PLUG;
  endfunction : stop_mode

  // mode expected while stopping on servo off above the brake speed
  function automatic logic [2:0] off_mode_exp(input int m);
    return (m % 2 == 1) ? MODE_COAST : MODE_DYN;
  endfunction : off_mode_exp

  // terminal level for a selector code while the brake is released, low = on
  function automatic logic term_exp(input logic [3:0] code, input logic otf);
    if (code == FN_BRAKE) return 1'b0;
    else if (code == FN_OT) return !otf;
    else if (code > 4'hB) return 1'b1;
    else return !fstat[code];
  endfunction : term_exp

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  // 250 MHz clock
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end

  // watchdog against a hang
  initial begin
    #200000;
    num_errors++;
    final_report();
  end

  // main sequence
  initial begin
    repeat (12) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    chk("mode", MODE_COAST, cmd.mode);
    chk("brake", 1, brake_n);
    chk("term", 7, term_n);
    bus(0, A_PLUG, 0);
    chk("plug", PLUG_RST, rd);
    bus(0, A_OFUNC, 0);
    chk("ofunc", OFUNC_RST, rd);
    bus(0, A_SON, 0);
    chk("son", SON_RST, rd);
    bus(0, A_BWAIT, 0);
    chk("bwait", BWAIT_RST, rd);
    bus(1, 8'h20, 32'hFFFFFFFF);
    bus(0, 8'h20, 0);
    chk("unmapped", 0, rd);
    for (int m = 0; m <= 5; m++) begin
      g = m % 3;
      lim = 9'($unsigned($random(seed)) % 301);
      fstat <= 12'($random(seed));
      bus(1, A_STOP, m);
      bus(0, A_STAT, 0);
      chk("method", (m == 0) ? 0 : m - 1, rd[10:8]);
      power_ok <= 1'b0;
      repeat (8) @(posedge clock_in);
      power_ok <= 1'b1;
      repeat (8) @(posedge clock_in);
      bus(0, A_STAT, 0);
      chk("method", m, rd[10:8]);
      for (int d = 0; d < 3; d++) begin
        ofunc[4*d +: 4] = (d == g) ? FN_BRAKE : codes[$unsigned($random(seed)) % 12];
      end
      bus(1, A_OFUNC, ofunc);
      bus(1, A_PLUG, lim);
      speed <= 16'd500;
      dir_fwd <= (m % 2 == 0);
      servo_on <= 1'b1;
      wait_brake(0, 100);
      repeat (4) @(posedge clock_in);
      chk("mode", MODE_DRIVE, cmd.mode);
      chk("relay", 1, relay_on);
      for (int d = 0; d < 3; d++) begin
        chk("term", term_exp(ofunc[4*d +: 4], 1'b0), term_n[d]);
      end
      // trip the limit in the direction of motion
      fwd_hit <= (m % 2 == 0);
      rev_hit <= (m % 2 == 1);
      repeat (8) @(posedge clock_in);
      chk("mode", stop_mode(m), cmd.mode);
      chk("torque", (m > 1) ? lim : TRQ_MAX, cmd.torque_limit);
      for (int d = 0; d < 3; d++) begin
        chk("term", term_exp(ofunc[4*d +: 4], 1'b1), term_n[d]);
      end
      speed <= 16'd0;
      repeat (8) @(posedge clock_in);
      chk("mode", (m > 3) ? MODE_ZCLAMP : MODE_COAST, cmd.mode);
      chk("zero_ref", m > 3, cmd.zero_ref);
      fwd_hit <= 1'b0;
      rev_hit <= 1'b0;
      repeat (8) @(posedge clock_in);
      chk("mode", MODE_DRIVE, cmd.mode);
      servo_on <= 1'b0;
      wait_brake(1, 12);
      // servo off while still turning: stop mode of the method, brake held released
      servo_on <= 1'b1;
      speed <= 16'h01F4;
      wait_brake(0, 100);
      repeat (2) @(posedge clock_in);
      servo_on <= 1'b0;
      repeat (8) @(posedge clock_in);
      chk("mode", off_mode_exp(m), cmd.mode);
      chk("brake", 0, brake_n);
      speed <= 16'h0000;
      wait_brake(1, 12);
    end
    // running stop ended by low speed
    servo_on <= 1'b1;
    speed <= 16'd800;
    wait_brake(0, 100);
    alarm <= 1'b1;
    repeat (8) @(posedge clock_in);
    chk("brake", 0, brake_n);
    speed <= 16'd99;
    wait_brake(1, 12);
    // running stop ended by the wait time, 10 ms = 40 cycles
    alarm <= 1'b0;
    speed <= 16'd800;
    wait_brake(0, 100);
    bus(1, A_BWAIT, 1);
    alarm <= 1'b1;
    repeat (20) @(posedge clock_in);
    chk("brake", 0, brake_n);
    wait_brake(1, 40);
    // servo on delay of +2 ms, base wait of 10 ms, then servo on delay of -2 ms
    bus(1, A_SON, 2);
    bus(1, A_BASE, 1);
    alarm <= 1'b0;
    speed <= 16'h0000;
    repeat (4) @(posedge clock_in);
    chk("brake", 0, brake_n);
    chk("mode", MODE_COAST, cmd.mode);
    repeat (8) @(posedge clock_in);
    chk("mode", MODE_DRIVE, cmd.mode);
    servo_on <= 1'b0;
    wait_brake(1, 12);
    repeat (20) @(posedge clock_in);
    chk("mode", MODE_DRIVE, cmd.mode);
    repeat (30) @(posedge clock_in);
    chk("mode", MODE_COAST, cmd.mode);
    bus(1, A_SON, 32'h0000_0FFE);
    servo_on <= 1'b1;
    repeat (8) @(posedge clock_in);
    chk("mode", MODE_DRIVE, cmd.mode);
    chk("brake", 1, brake_n);
    wait_brake(0, 20);
    final_report();
  end
endmodule : testbench
